// ===== bdc_top.sv
`timescale 1ns/100ps
`include "bdc_map.svh"
module bdc_top
   import bdc_pkg::*;
#(
   parameter int LAT_FAST = `BDC_LAT_FAST,
   parameter int LAT_SLOW = `BDC_LAT_SLOW
)(
   input  wire logic        i_mclk,
   input  wire logic        i_srst,
   // AHB-Lite slave
   input  wire logic        i_hsel,
   input  wire logic [31:0] i_haddr,
   input  wire logic [1:0]  i_htrans,
   input  wire logic        i_hwrite,
   input  wire logic [2:0]  i_hsize,
   input  wire logic [31:0] i_hwdata,
   input  wire logic        i_hready,
   output logic             o_hreadyout,
   output logic             o_hresp,
   output logic [31:0]      o_hrdata,
   // System side
   input  wire logic        i_sysclk_is_32k,
   input  wire logic [11:0] i_wavegen_code,
   input  wire logic        i_wavegen_valid,
   // Analog side
   output logic [11:0]      o_bias_code,
   output logic [5:0]       o_zero_code,
   output logic [5:0]       o_main_tap,
   output logic [5:0]       o_sub_tap,
   output logic             o_zero_trim,
   output logic [11:0]      o_zero_fine_steps,
   output logic             o_update_busy,
   output logic [4:0]       o_switch,
   output logic             o_zero_to_hs_tia,
   output logic             o_dac_power_down,
   output logic             o_ref_sel_avdd,
   output logic             o_bias_mux,
   output logic             o_zero_mux,
   output logic [31:0]      o_ref_buf_cfg,
   output logic [31:0]      o_cm_switch_sel
);

   typedef struct packed {
      bdc_phase_t   phase;
      logic [15:0]  addr;
      logic [31:0]  rdata;
      logic         ready;
      logic [31:0]  ref_buf;
      bdc_code_t    code;
      bdc_sw_ctrl_t swc;
      bdc_cfg_t     cfg;
      logic [31:0]  cm_sel;
      logic [4:0]   sw;
      logic         zero_hs;
      logic [5:0]   main_tap;
      logic [5:0]   sub_tap;
   } bdc_top_st_t;

   bdc_top_st_t st_r;
   bdc_top_st_t st_nxt;

   logic         addr_take;
   logic         wr_data;
   logic         code_load;
   bdc_code_t    load_code;
   bdc_code_t    applied;
   logic [4:0]   sw_dec;
   logic         zero_hs_dec;
   logic         lat_busy;
   logic         lat_trim;
   logic [11:0]  lat_fine;

   function automatic logic [31:0] rd_mux(
      input logic [15:0] a,
      input bdc_top_st_t s
   );
      logic [31:0] v;
      v = 32'h0000_0000;
      unique case (a)
         `BDC_OFS_REF_BUF: v = s.ref_buf;
         `BDC_OFS_CODE:    v = {14'h0000, s.code};
         `BDC_OFS_SW_CTRL: v = {26'h000_0000, s.swc};
         `BDC_OFS_CONFIG:  v = {25'h000_0000, s.cfg};
         `BDC_OFS_CM_SEL:  v = s.cm_sel;
         default:          v = 32'h0000_0000;
      endcase
      return v;
   endfunction

   // Address phase accepted: selected NONSEQ or SEQ with bus ready
   assign addr_take = i_hsel & i_htrans[1] & i_hready;
   assign wr_data   = (st_r.phase == BDC_PH_WRITE);

   always_comb begin
      st_nxt    = st_r;
      code_load = 1'b0;
      load_code = st_r.code;

      // Data phase of a write: store into the addressed register
      if (wr_data) begin
         unique case (st_r.addr)
            `BDC_OFS_REF_BUF: begin
               st_nxt.ref_buf = i_hwdata;
            end
            `BDC_OFS_CODE: begin
               if (st_r.cfg.write_en) begin
                  st_nxt.code.bias = i_hwdata[`BDC_CODE_BIAS_LSB +: 12]; // R1
                  st_nxt.code.zero = i_hwdata[`BDC_CODE_ZERO_LSB +: 6]; // R2
                  code_load = ~st_r.cfg.src_wavegen; // R21
               end
            end
            `BDC_OFS_SW_CTRL: begin
               st_nxt.swc = i_hwdata[5:0]; // R9
            end
            `BDC_OFS_CONFIG: begin
               st_nxt.cfg = i_hwdata[6:0];
               if (!st_nxt.cfg.write_en && st_r.code != `BDC_RST_CODE) begin
                  st_nxt.code = `BDC_RST_CODE; // R19
                  code_load   = ~st_nxt.cfg.src_wavegen;
               end
            end
            `BDC_OFS_CM_SEL: begin
               st_nxt.cm_sel = i_hwdata; // R16
            end
            default: begin
            end
         endcase
      end

      // Waveform generator feeds the bias code directly
      if (st_nxt.cfg.src_wavegen) begin
         if (i_wavegen_valid) begin
            code_load      = 1'b1; // R21
            load_code.bias = i_wavegen_code;
            load_code.zero = st_nxt.code.zero;
         end else begin
            code_load = 1'b0;
            load_code = st_nxt.code;
         end
      end else begin
         load_code = st_nxt.code;
      end

      // Address phase: decode and prepare read data
      if (addr_take) begin
         st_nxt.addr  = i_haddr[15:0];
         st_nxt.phase = i_hwrite ? BDC_PH_WRITE : BDC_PH_READ;
         st_nxt.rdata = i_hwrite ? 32'h0000_0000
                                 : rd_mux(i_haddr[15:0], st_nxt);
      end else if (i_hready) begin
         st_nxt.phase = BDC_PH_IDLE;
      end

      st_nxt.ready    = 1'b1;
      st_nxt.sw       = sw_dec;
      st_nxt.zero_hs  = zero_hs_dec;
      st_nxt.main_tap = applied.bias[11:6]; // R13
      st_nxt.sub_tap  = applied.bias[5:0]; // R13
   end

   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         st_r          <= '0;
         st_r.ready    <= 1'b1;
         st_r.ref_buf  <= `BDC_RST_REF_BUF;
         st_r.code     <= `BDC_RST_CODE; // R18
         st_r.swc      <= `BDC_RST_SW_CTRL; // R18
         st_r.cfg      <= `BDC_RST_CONFIG; // R18 R20
         st_r.cm_sel   <= `BDC_RST_CM_SEL;
      end else begin
         st_r <= st_nxt;
      end
   end

   bdc_switch_decode u_sw (
      .i_cfg     (st_nxt.cfg),
      .i_swc     (st_nxt.swc),
      .o_sw      (sw_dec),
      .o_zero_hs (zero_hs_dec)
   );

   bdc_update_latch #(
      .LAT_FAST (LAT_FAST),
      .LAT_SLOW (LAT_SLOW)
   ) u_lat (
      .i_mclk      (i_mclk),
      .i_srst      (i_srst),
      .i_load      (code_load),
      .i_code      (load_code),
      .i_is_32k    (i_sysclk_is_32k),
      .o_code      (applied),
      .o_busy      (lat_busy),
      .o_zero_trim (lat_trim),
      .o_zero_fine (lat_fine)
   );

   assign o_hreadyout       = st_r.ready;
   assign o_hresp           = 1'b0;
   assign o_hrdata          = st_r.rdata;

   // Code zero is the 0.2 V end of the linear span
   assign o_bias_code       = applied.bias; // R11
   assign o_zero_code       = applied.zero;
   assign o_main_tap        = st_r.main_tap;
   assign o_sub_tap         = st_r.sub_tap;
   assign o_zero_trim       = lat_trim;
   assign o_zero_fine_steps = lat_fine;
   assign o_update_busy     = lat_busy;

   assign o_switch          = st_r.sw;
   assign o_zero_to_hs_tia  = st_r.zero_hs;
   assign o_dac_power_down  = st_r.cfg.power_down; // R20
   assign o_ref_sel_avdd    = st_r.cfg.ref_sel;
   assign o_bias_mux        = st_r.cfg.bias_mux;
   assign o_zero_mux        = st_r.cfg.zero_mux;
   assign o_ref_buf_cfg     = st_r.ref_buf;
   assign o_cm_switch_sel   = st_r.cm_sel;

endmodule

// ===== bdc_map.svh
// Contract
// [R1] Bias code is taken from code register bits 11 to 0.
// [R2] Zero-level code is taken from code register bits 17 to 12.
// [R3] On a 16 MHz system clock a code write reaches outputs after ten cycles.
// [R4] On a 32 kHz system clock a code write reaches outputs after one cycle.
// [R5] Controller waits the update latency before relying on output or sleeping.
// [R6] Normal mode closes switches two and three, opens zero, one and four.
// [R7] Diagnostic mode closes switches zero and four, opens all others.
// [R8] Diagnostic mode routes zero-level output to the high speed TIA.
// [R9] Override bit makes each switch follow its own low switch-control bit.
// [R10] Waveform generator as code source needs the 32 kHz system clock.
// [R11] Bias output spans 0.2 V to 2.4 V linearly; code zero is 0.2 V.
// [R12] One zero-level step equals sixty-four bias steps.
// [R13] Upper bias bits pick a main-string resistor; lower bits pick sub-tap.
// [R14] Zero-level sits one bias step low when bias is below zero-level.
// [R15] Software decrements bias code when below sixty-four times zero code.
// [R16] Four-wire isolated measurement needs common-mode select bit three set.
// [R17] Bias-held spectroscopy needs diagnostic mode and front end bit 21 set.
// [R18] Reset: config reads 0x2, code and switch control read zero.
// [R19] With write enable clear the code register holds zero, ignores writes.
// [R20] Power-down, set at reset, powers the DAC off and opens all switches.
// [R21] Config bit six picks code source: register or waveform generator.
// [R22] During update latency outputs keep the previously applied code.
`ifndef BDC_MAP_SVH
`define BDC_MAP_SVH

`define BDC_OFS_REF_BUF    16'h2050
`define BDC_OFS_CODE       16'h2120
`define BDC_OFS_SW_CTRL    16'h2124
`define BDC_OFS_CONFIG     16'h2128
`define BDC_OFS_CM_SEL     16'h235C

`define BDC_RST_REF_BUF    32'h0000_0000
`define BDC_RST_CODE       18'h0_0000
`define BDC_RST_SW_CTRL    6'h00
`define BDC_RST_CONFIG     7'h02
`define BDC_RST_CM_SEL     32'h0000_0000

`define BDC_CODE_BIAS_LSB  0
`define BDC_CODE_ZERO_LSB  12
`define BDC_ZERO_SCALE_SH  6

`define BDC_LAT_FAST       10
`define BDC_LAT_SLOW       1

`define BDC_BIAS_MIN_UV    200000
`define BDC_BIAS_MAX_UV    2400000

`endif

// ===== bdc_pkg.sv
package bdc_pkg;

   typedef struct packed {
      logic [5:0]  zero;
      logic [11:0] bias;
   } bdc_code_t;

   typedef struct packed {
      logic src_wavegen;
      logic diag_mode;
      logic zero_mux;
      logic bias_mux;
      logic ref_sel;
      logic power_down;
      logic write_en;
   } bdc_cfg_t;

   typedef struct packed {
      logic       override;
      logic [4:0] sw;
   } bdc_sw_ctrl_t;

   typedef enum logic [1:0] {
      BDC_PH_IDLE  = 2'b00,
      BDC_PH_WRITE = 2'b01,
      BDC_PH_READ  = 2'b11
   } bdc_phase_t;

endpackage

// ===== bdc_switch_decode.sv
`timescale 1ns/100ps
module bdc_switch_decode
   import bdc_pkg::*;
(
   input  wire bdc_cfg_t     i_cfg,
   input  wire bdc_sw_ctrl_t i_swc,
   output logic [4:0]        o_sw,
   output logic              o_zero_hs
);
   localparam logic [4:0] NORMAL_SET = 5'h0C;
   localparam logic [4:0] DIAG_SET   = 5'h11;

   genvar g;
   generate
      for (g = 0; g < 5; g++) begin : g_sw
         always_comb begin
            if (i_cfg.power_down) begin
               o_sw[g] = 1'b0; // R20
            end else if (i_swc.override) begin
               o_sw[g] = i_swc.sw[g]; // R9
            end else if (i_cfg.diag_mode) begin
               o_sw[g] = DIAG_SET[g]; // R7
            end else begin
               o_sw[g] = NORMAL_SET[g]; // R6
            end
         end
      end
   endgenerate

   always_comb begin
      o_zero_hs = i_cfg.diag_mode & ~i_cfg.power_down; // R8
   end
endmodule

// ===== bdc_update_latch.sv
`timescale 1ns/100ps
`include "bdc_map.svh"
module bdc_update_latch
   import bdc_pkg::*;
#(
   parameter int LAT_FAST = `BDC_LAT_FAST,
   parameter int LAT_SLOW = `BDC_LAT_SLOW
)(
   input  wire logic      i_mclk,
   input  wire logic      i_srst,
   input  wire logic      i_load,
   input  wire bdc_code_t i_code,
   input  wire logic      i_is_32k,
   output bdc_code_t      o_code,
   output logic           o_busy,
   output logic           o_zero_trim,
   output logic [11:0]    o_zero_fine
);
   generate
      if (LAT_FAST < 1 || LAT_FAST > 15 || LAT_SLOW < 1 || LAT_SLOW > 15)
      begin : g_chk
         $error("bdc_update_latch: latency must be 1 to 15");
      end
   endgenerate

   localparam logic [3:0] CNT_FAST = 4'(LAT_FAST - 1);
   localparam logic [3:0] CNT_SLOW = 4'(LAT_SLOW - 1);

   typedef struct packed {
      bdc_code_t   pend;
      logic [3:0]  cnt;
      logic        busy;
      bdc_code_t   applied;
      logic        trim;
      logic [11:0] fine;
   } bdc_lat_st_t;

   bdc_lat_st_t st_r;
   bdc_lat_st_t st_nxt;
   logic [11:0] zero_scaled;

   always_comb begin
      st_nxt = st_r;
      zero_scaled = 12'h000;
      if (i_load) begin
         st_nxt.pend = i_code;
         st_nxt.busy = 1'b1;
         st_nxt.cnt  = i_is_32k ? CNT_SLOW : CNT_FAST; // R3 R4
      end else if (st_r.busy) begin
         if (st_r.cnt == 4'h0) begin
            st_nxt.applied = st_r.pend; // R22
            st_nxt.busy    = 1'b0;
         end else begin
            st_nxt.cnt = st_r.cnt - 4'h1;
         end
      end
      zero_scaled = {st_nxt.applied.zero, 6'h00}; // R12
      st_nxt.trim = st_nxt.applied.bias < zero_scaled; // R14
      st_nxt.fine = zero_scaled - {11'h000, st_nxt.trim}; // R14
   end

   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign o_code      = st_r.applied;
   assign o_busy      = st_r.busy;
   assign o_zero_trim = st_r.trim;
   assign o_zero_fine = st_r.fine;
endmodule

// ===== bdc_top_chk.sv
`timescale 1ns/100ps
module bdc_top_chk
   import bdc_pkg::*;
#(
   parameter int LAT_FAST = 10,
   parameter int LAT_SLOW = 1
)(
   input wire logic        i_mclk,
   input wire logic        i_srst,
   input wire logic        i_sysclk_is_32k,
   input wire logic [11:0] o_bias_code,
   input wire logic [5:0]  o_zero_code,
   input wire logic [5:0]  o_main_tap,
   input wire logic [5:0]  o_sub_tap,
   input wire logic        o_zero_trim,
   input wire logic [11:0] o_zero_fine_steps,
   input wire logic        o_update_busy,
   input wire logic [4:0]  o_switch,
   input wire logic        o_zero_to_hs_tia,
   input wire logic        o_dac_power_down
);
   logic [4:0] busy_cnt_r;
   logic [4:0] lat_exp;
   assign lat_exp = i_sysclk_is_32k ? 5'(LAT_SLOW) : 5'(LAT_FAST);
   // Length of the busy window
   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         busy_cnt_r <= 5'h00;
      end else begin
         busy_cnt_r <= o_update_busy ? 5'(busy_cnt_r + 5'h01) : 5'h00;
      end
   end
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (i_srst);
   pd_open_a: assert property (
      o_dac_power_down |-> o_switch == 5'h00) else $error("switch closed");
   hs_route_a: assert property (
      o_zero_to_hs_tia |-> !o_dac_power_down) else $error("bad hs route");
   lat_len_a: assert property (
      $fell(o_update_busy) |-> busy_cnt_r == lat_exp) else $error("latency");
   bias_hold_a: assert property (
      !$stable(o_bias_code) |-> $fell(o_update_busy)) else $error("bias early");
   zero_hold_a: assert property (
      !$stable(o_zero_code) |-> $fell(o_update_busy)) else $error("zero early");
   tap_split_a: assert property (
      o_main_tap == $past(o_bias_code[11:6])
      && o_sub_tap == $past(o_bias_code[5:0])) else $error("tap split");
   trim_flag_a: assert property (
      o_zero_trim == (o_bias_code < {o_zero_code, 6'h00})) else $error("trim");
   fine_step_a: assert property (
      o_zero_fine_steps == {o_zero_code, 6'h00} - 12'(o_zero_trim))
      else $error("fine steps");
   cover property ($fell(o_update_busy));
   cover property (o_switch == 5'h11);
   cover property (o_zero_trim);
endmodule

bind bdc_top bdc_top_chk #(.LAT_FAST(LAT_FAST), .LAT_SLOW(LAT_SLOW)) u_chk (
   .i_mclk(i_mclk), .i_srst(i_srst), .i_sysclk_is_32k(i_sysclk_is_32k),
   .o_bias_code(o_bias_code), .o_zero_code(o_zero_code),
   .o_main_tap(o_main_tap), .o_sub_tap(o_sub_tap),
   .o_zero_trim(o_zero_trim), .o_zero_fine_steps(o_zero_fine_steps),
   .o_update_busy(o_update_busy), .o_switch(o_switch),
   .o_zero_to_hs_tia(o_zero_to_hs_tia), .o_dac_power_down(o_dac_power_down));

// ===== bdc_analog_model.sv
`timescale 1ns/100ps
module bdc_analog_model (
   input  wire logic [11:0] i_bias_code,
   input  wire logic [5:0]  i_zero_code,
   input  wire logic        i_zero_trim,
   input  wire logic [4:0]  i_switch,
   input  wire logic        i_power_down,
   output int               o_bias_uv,
   output int               o_zero_uv,
   output logic [4:0]       o_closed
);
   // Linear string from 0.2 V, step of 2.2 V over 4095
   assign o_bias_uv = 200000
      + int'(64'(i_bias_code) * 2200000 / 4095);
   // Loading drops the zero level by one bias step
   assign o_zero_uv = 200000 + int'((64'({i_zero_code, 6'h00})
      - 64'(i_zero_trim)) * 2200000 / 4095);
   assign o_closed = i_power_down ? 5'h00 : i_switch;
endmodule

// ===== bias_dac_control_test.sv
`timescale 1ns/100ps
`include "bdc_map.svh"
module bias_dac_control_test;
   import bdc_pkg::*;
   logic i_mclk = 0, i_srst = 1, hsel = 0, hwrite = 0, is32k = 0, wg_v = 0;
   logic [31:0] haddr = 0, hwdata = 0, hrdata, d;
   logic [1:0] htrans = 0;
   logic [11:0] wg_c = 0, bias, fine;
   logic [5:0] zero, mtap, stap;
   logic [4:0] sw, closed;
   logic hrdy, trim, busy, hs, pd;
   logic resp, rsel, bmux, zmux;
   logic [31:0] rbuf, cms;
   int num_errors = 0, cmp_count = 0, n, buv, zuv;
   always #5 i_mclk = ~i_mclk;
   bdc_top u_bdc_top (.i_mclk(i_mclk), .i_srst(i_srst), .i_hsel(hsel),
      .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
      .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hrdy),
      .o_hreadyout(hrdy), .o_hresp(resp), .o_hrdata(hrdata),
      .i_sysclk_is_32k(is32k), .i_wavegen_code(wg_c),
      .i_wavegen_valid(wg_v), .o_bias_code(bias), .o_zero_code(zero),
      .o_main_tap(mtap), .o_sub_tap(stap), .o_zero_trim(trim),
      .o_zero_fine_steps(fine), .o_update_busy(busy), .o_switch(sw),
      .o_zero_to_hs_tia(hs), .o_dac_power_down(pd),
      .o_ref_sel_avdd(rsel), .o_bias_mux(bmux), .o_zero_mux(zmux),
      .o_ref_buf_cfg(rbuf), .o_cm_switch_sel(cms));
   bdc_analog_model u_bdc_analog_model (.i_bias_code(bias),
      .i_zero_code(zero), .i_zero_trim(trim), .i_switch(sw),
      .i_power_down(pd), .o_bias_uv(buv), .o_zero_uv(zuv),
      .o_closed(closed));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("[FAIL] %0t seen %h exp %h", $time, seen, exp);
      end
   endtask
   task automatic xfer(input logic [15:0] a, input logic w,
                       input logic [31:0] wd);
      @(posedge i_mclk);
      hsel <= 1;
      haddr <= {16'h0000, a};
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge i_mclk); while (hrdy !== 1'b1);
      hsel <= 0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge i_mclk); while (hrdy !== 1'b1);
      d = hrdata;
      #1;
   endtask
   // Waits out the update latency before trusting the outputs
   task automatic lat(input logic [11:0] e);
      n = 0;
      do begin @(posedge i_mclk); #1; n++; end while (bias !== e && n < 40);
   endtask
   task automatic t_reset;
      xfer(`BDC_OFS_CONFIG, 0, 0); chk(d, 32'h0000_0002);
      xfer(`BDC_OFS_CODE, 0, 0); chk(d, 32'h0000_0000);
      xfer(`BDC_OFS_SW_CTRL, 0, 0); chk(d, 32'h0000_0000);
      chk(sw, 5'h00); chk(pd, 1'b1);
      xfer(`BDC_OFS_CODE, 1, 32'h0001_1234);
      xfer(`BDC_OFS_CODE, 0, 0); chk(d, 32'h0000_0000);
      $display("reset and lock test done");
   endtask
   task automatic t_code;
      xfer(`BDC_OFS_CONFIG, 1, 32'h0000_0001); chk(sw, 5'h0C);
      xfer(`BDC_OFS_CODE, 1, 32'h0000_5123);
      chk(busy, 1'b1);
      lat(12'h123); chk(n, 10);
      chk(busy, 1'b0);
      chk(zero, 6'h05); chk(trim, 1'b1); chk(fine, 12'h13F);
      chk(zuv, 32'h0005_AAB3);
      @(posedge i_mclk); #1;
      chk(mtap, 6'h04); chk(stap, 6'h23);
      xfer(`BDC_OFS_CODE, 0, 0); chk(d, 32'h0000_5123);
      // Software-side trim: bias one below 64 times the zero code
      xfer(`BDC_OFS_CODE, 1, 32'h0000_513F);
      lat(12'h13F); chk(n, 10);
      chk(buv, 32'h0005_AAB3);
      chk(zuv, 32'h0005_AAB3);
      @(posedge i_mclk) is32k <= 1;
      xfer(`BDC_OFS_CODE, 1, 32'h0000_1FFF);
      lat(12'hFFF); chk(n, 1);
      chk(trim, 1'b0); chk(buv, 32'h0024_9F00);
      $display("code latency test done");
   endtask
   task automatic t_modes;
      xfer(`BDC_OFS_CONFIG, 1, 32'h0000_0021); chk(sw, 5'h11);
      chk(hs, 1'b1);
      xfer(`BDC_OFS_SW_CTRL, 1, 32'h0000_002A); chk(sw, 5'h0A);
      xfer(`BDC_OFS_CONFIG, 1, 32'h0000_0023); chk(sw, 5'h00);
      chk(closed, 5'h00); chk(hs, 1'b0);
      xfer(`BDC_OFS_SW_CTRL, 1, 32'h0000_0000);
      $display("switch mode test done");
   endtask
   task automatic t_wave;
      xfer(`BDC_OFS_CONFIG, 1, 32'h0000_0041);
      @(posedge i_mclk);
      wg_c <= 12'h0AB;
      wg_v <= 1;
      @(posedge i_mclk) wg_v <= 0;
      lat(12'h0AB); chk(n, 1); chk(zero, 6'h01);
      xfer(`BDC_OFS_CODE, 1, 32'h0000_2222);
      repeat (12) @(posedge i_mclk);
      #1 chk(bias, 12'h0AB);
      xfer(`BDC_OFS_CONFIG, 1, 32'h0000_0000);
      lat(12'h000); chk(n, 1);
      @(posedge i_mclk) is32k <= 0;
      xfer(`BDC_OFS_CODE, 0, 0); chk(d, 32'h0000_0000);
      $display("wavegen test done");
   endtask
   task automatic t_misc;
      xfer(`BDC_OFS_REF_BUF, 1, 32'hA5A5_5A5A);
      xfer(`BDC_OFS_REF_BUF, 0, 0); chk(d, 32'hA5A5_5A5A);
      chk(rbuf, 32'hA5A5_5A5A);
      chk(resp, 1'b0);
      xfer(`BDC_OFS_CM_SEL, 1, 32'h0000_0008);
      xfer(`BDC_OFS_CM_SEL, 0, 0); chk(d, 32'h0000_0008);
      chk(cms, 32'h0000_0008);
      xfer(`BDC_OFS_CONFIG, 1, 32'h0000_001D);
      chk(rsel, 1'b1);
      chk(bmux, 1'b1);
      chk(zmux, 1'b1);
      chk(pd, 1'b0);
      xfer(16'h2000, 1, 32'hFFFF_FFFF);
      xfer(16'h2000, 0, 0); chk(d, 32'h0000_0000);
      $display("register test done");
   endtask
   task automatic tally_and_finish;
      $display("compares %0d errors %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   initial begin
      repeat (8) @(posedge i_mclk);
      i_srst <= 0;
      t_reset;
      t_code;
      t_modes;
      t_wave;
      t_misc;
      tally_and_finish;
   end
   initial begin
      #200000;
      num_errors++;
      tally_and_finish;
   end
endmodule
